// ---- rtl/simd_double_fp_exception_map.sv ----
/*
 Exception map for packed and scalar double-precision vector instructions:
 gates datapath-detected conditions by instruction class, keeps the sticky
 control/status register, and raises the trap or default-result indication.
 Assumes the decode/execute pipeline runs on clk_sys and presents one
 instruction per cycle with lane conditions already detected.
*/
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps

module simd_double_fp_exception_map
   import simd_fp_exc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic op_valid,
   input wire logic [5:0] op_class,
   input wire logic op_packed,
   input wire logic [5:0] op_cond_lo,
   input wire logic [5:0] op_cond_hi,
   output logic res_valid,
   output logic [5:0] res_cond,
   output logic default_result,
   output logic simd_fp_trap,
   output logic [7:0] trap_vector,
   output logic [1:0] round_mode,
   output logic gpr_write
);

   state_t st_r;
   state_t st_nxt;
   op_class_t cls;
   logic [5:0] lanes;
   logic [5:0] raised;
   logic [5:0] unmasked;
   logic [31:0] csr_word;
   logic [31:0] evt_word;
   logic [31:0] be_m;
   logic [31:0] csr_new;

   localparam state_t state_reset = '{
      bus: bus_idle,
      waitreq: 1'b1,
      rdata: 32'h0000_0000,
      flags: flags_reset,
      masks: masks_reset,
      rmode: rmode_reset,
      last_raised: 6'h00,
      last_class: 6'h00,
      trap_cnt: 16'h0000,
      res_valid: 1'b0,
      res_cond: 6'h00,
      dflt: 1'b0,
      trap: 1'b0,
      vec: 8'h00,
      rnd: rmode_reset,
      gpr_wr: 1'b0
   };

   function automatic logic [5:0] permit(input op_class_t c);
      case (c)
         add_packed_double, add_scalar_double:
            permit = perm_arith;
         subtract_packed_double, subtract_scalar_double:
            permit = perm_arith;
         multiply_packed_double, multiply_scalar_double:
            permit = perm_arith;
         divide_packed_double, divide_scalar_double:
            permit = perm_all;
         compare_packed_double, compare_scalar_double:
            permit = perm_inv_den;
         ordered_flag_compare, unordered_flag_compare:
            permit = perm_inv_den;
         max_packed_double, max_scalar_double, min_packed_double, min_scalar_double:
            permit = perm_inv_den;
         sqrt_packed_double, sqrt_scalar_double:
            permit = perm_sqrt;
         int_to_single_packed:
            permit = perm_prec;
         single_to_int_round, single_to_int_trunc, double_to_int_round, double_to_int_trunc,
         double_to_mmx_int_round, double_to_mmx_int_trunc,
         scalar_double_to_gpr_round, scalar_double_to_gpr_trunc:
            permit = perm_inv_prec;
         double_to_single_packed, scalar_double_to_single:
            permit = perm_arith;
         single_to_double_packed, scalar_single_to_double:
            permit = perm_inv_den;
         int_to_double_packed, mmx_int_to_double, gpr_int_to_scalar_double:
            permit = perm_none;
         and_128, and_not_128, or_128, xor_128:
            permit = perm_none;
         aligned_move_128, unaligned_move_128:
            permit = perm_none;
         high_half_move, low_half_move, scalar_move:
            permit = perm_none;
         sign_mask_extract, shuffle_double, interleave_high_double, interleave_low_double:
            permit = perm_none;
         // unknown codes never raise, so a decode slip cannot fake a trap
         default:
            permit = perm_none;
      endcase
   endfunction

   function automatic logic is_trunc(input op_class_t c);
      case (c)
         single_to_int_trunc, double_to_int_trunc, double_to_mmx_int_trunc, scalar_double_to_gpr_trunc:
            is_trunc = 1'b1;
         default:
            is_trunc = 1'b0;
      endcase
   endfunction

   function automatic logic is_gpr(input op_class_t c);
      case (c)
         scalar_double_to_gpr_round, scalar_double_to_gpr_trunc, sign_mask_extract:
            is_gpr = 1'b1;
         default:
            is_gpr = 1'b0;
      endcase
   endfunction

   function automatic logic [31:0] be_mask(input logic [3:0] be);
      be_mask = 32'h0000_0000;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
         begin
            be_mask[i*8 +: 8] = 8'hff;
         end
      end
   endfunction

   assign cls = op_class_t'(op_class);

   always_comb
   begin
      csr_word = 32'h0000_0000;
      csr_word[flag_lsb +: cond_w] = st_r.flags;
      csr_word[mask_lsb +: cond_w] = st_r.masks;
      csr_word[rmode_lsb +: 2] = st_r.rmode;
      evt_word = 32'h0000_0000;
      evt_word[last_raised_lsb +: cond_w] = st_r.last_raised;
      evt_word[last_class_lsb +: cond_w] = st_r.last_class;
      evt_word[trap_cnt_lsb +: 16] = st_r.trap_cnt;
      be_m = be_mask(avs_byteenable);
      csr_new = (csr_word & ~be_m) | (avs_writedata & be_m);
   end

   always_comb
   begin
      st_nxt = st_r;
      // both lanes of a packed op fold into one vector (scalar ops take the low lane only); the lane is not kept
      lanes = op_cond_lo | (op_packed ? op_cond_hi : 6'h00);
      raised = op_valid ? (lanes & permit(cls)) : 6'h00;
      unmasked = raised & ~st_r.masks;

      st_nxt.res_valid = op_valid;
      st_nxt.res_cond = raised;
      st_nxt.trap = |unmasked;
      st_nxt.vec = (|unmasked) ? trap_vector_num : 8'h00;
      st_nxt.dflt = (|raised) && !(|unmasked);
      st_nxt.gpr_wr = op_valid && is_gpr(cls);
      if (op_valid)
      begin
         st_nxt.rnd = is_trunc(cls) ? rmode_toward_zero : st_r.rmode;
      end
      if (|raised)
      begin
         st_nxt.last_raised = raised;
         st_nxt.last_class = op_class;
      end
      if (|unmasked)
      begin
         st_nxt.trap_cnt = st_r.trap_cnt + trap_cnt_one;
      end

      case (st_r.bus)
         bus_idle:
         begin
            if (avs_read || avs_write)
            begin
               st_nxt.bus = bus_ack;
               st_nxt.waitreq = 1'b0;
               if (avs_read && avs_address == csr_addr)
               begin
                  st_nxt.rdata = csr_word;
               end
               else if (avs_read && avs_address == evt_addr)
               begin
                  st_nxt.rdata = evt_word;
               end
               else
               begin
                  st_nxt.rdata = 32'h0000_0000;
               end
            end
         end
         bus_ack:
         begin
            st_nxt.bus = bus_idle;
            st_nxt.waitreq = 1'b1;
            if (avs_write && avs_address == csr_addr)
            begin
               st_nxt.flags = csr_new[flag_lsb +: cond_w];
               st_nxt.masks = csr_new[mask_lsb +: cond_w];
               st_nxt.rmode = csr_new[rmode_lsb +: 2];
            end
         end
         default:
         begin
            st_nxt.bus = bus_idle;
            st_nxt.waitreq = 1'b1;
         end
      endcase

      // set after the software write, so a new event beats a clear
      st_nxt.flags = st_nxt.flags | raised;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         st_r <= state_reset;
      end
      else if (ce)
      begin
         st_r <= st_nxt;
      end
   end

   assign avs_readdata = st_r.rdata;
   assign avs_waitrequest = st_r.waitreq;
   assign res_valid = st_r.res_valid;
   assign res_cond = st_r.res_cond;
   assign default_result = st_r.dflt;
   assign simd_fp_trap = st_r.trap;
   assign trap_vector = st_r.vec;
   assign round_mode = st_r.rnd;
   assign gpr_write = st_r.gpr_wr;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);

   a_add_no_divz:
   assert property (ce && op_valid && (cls == add_packed_double || cls == add_scalar_double)
      |=> res_valid && !res_cond[cond_divz]) else $error("add raised divide-by-zero");
   a_div_all_pass:
   assert property (ce && op_valid && cls == divide_scalar_double
      |=> res_cond == $past(op_cond_lo | (op_packed ? op_cond_hi : 6'h00))) else $error("divide dropped a condition");
   a_mul_no_divz:
   assert property (ce && op_valid && (cls == multiply_packed_double || cls == multiply_scalar_double)
      |=> !res_cond[cond_divz]) else $error("multiply raised divide-by-zero");
   a_sub_no_divz:
   assert property (ce && op_valid && (cls == subtract_packed_double || cls == subtract_scalar_double)
      |=> !res_cond[cond_divz]) else $error("subtract raised divide-by-zero");
   a_cmp_inv_den:
   assert property (ce && op_valid && (cls == compare_packed_double || cls == compare_scalar_double)
      |=> (res_cond & ~perm_inv_den) == 6'h00) else $error("compare raised a forbidden condition");
   a_sqrt_limited:
   assert property (ce && op_valid && cls == sqrt_packed_double
      |=> res_cond == ($past(op_cond_lo | (op_packed ? op_cond_hi : 6'h00)) & perm_sqrt))
      else $error("square root condition set wrong");
   a_trunc_to_zero:
   assert property (ce && op_valid && is_trunc(cls) |=> round_mode == rmode_toward_zero)
      else $error("truncating conversion not rounded toward zero");
   a_move_silent:
   assert property (ce && op_valid && (cls == aligned_move_128 || cls == unaligned_move_128)
      |=> res_cond == 6'h00 && !simd_fp_trap) else $error("move raised a condition");
   a_masked_default:
   assert property (ce && op_valid && (raised != 6'h00) && ((raised & ~st_r.masks) == 6'h00)
      |=> default_result && !simd_fp_trap) else $error("masked condition trapped");
   a_unmasked_trap:
   assert property (ce && op_valid && ((raised & ~st_r.masks) != 6'h00)
      |=> simd_fp_trap && trap_vector == trap_vector_num && !default_result)
      else $error("unmasked condition gave no trap");
   a_sticky_flags:
   assert property (ce && op_valid |=> (st_r.flags & res_cond) == res_cond)
      else $error("raised condition missing from sticky flags");
   a_bus_answer:
   assert property ((avs_read || avs_write) && avs_waitrequest && ce && st_r.bus == bus_idle
      |=> !avs_waitrequest ##1 (avs_waitrequest || !ce)) else $error("bus answer not one cycle");
   a_flagcmp_inv_den:
   assert property (ce && op_valid && (cls == ordered_flag_compare || cls == unordered_flag_compare)
      |=> (res_cond & ~perm_inv_den) == 6'h00) else $error("flag compare raised a forbidden condition");
   a_minmax_inv_den:
   assert property (ce && op_valid && cls inside {max_packed_double, max_scalar_double, min_packed_double,
      min_scalar_double}
      |=> (res_cond & ~perm_inv_den) == 6'h00) else $error("max or min raised a forbidden condition");
   a_int_single_prec:
   assert property (ce && op_valid && cls == int_to_single_packed
      |=> (res_cond & ~perm_prec) == 6'h00) else $error("integer to single raised a forbidden condition");
   a_to_int_inv_prec:
   assert property (ce && op_valid && (is_trunc(cls) || cls inside {single_to_int_round, double_to_int_round,
      double_to_mmx_int_round, scalar_double_to_gpr_round})
      |=> (res_cond & ~perm_inv_prec) == 6'h00) else $error("float to integer raised a forbidden condition");
   a_round_gpr:
   assert property (ce && op_valid && cls == scalar_double_to_gpr_round
      |=> gpr_write && round_mode == $past(st_r.rmode)) else $error("rounding conversion mode or gpr write wrong");
   a_narrow_no_divz:
   assert property (ce && op_valid && (cls == double_to_single_packed || cls == scalar_double_to_single)
      |=> !res_cond[cond_divz]) else $error("narrowing conversion raised divide-by-zero");
   a_widen_inv_den:
   assert property (ce && op_valid && (cls == single_to_double_packed || cls == scalar_single_to_double)
      |=> (res_cond & ~perm_inv_den) == 6'h00) else $error("widening conversion raised a forbidden condition");
   a_int_double_silent:
   assert property (ce && op_valid && cls inside {int_to_double_packed, mmx_int_to_double, gpr_int_to_scalar_double}
      |=> res_cond == 6'h00 && !simd_fp_trap) else $error("integer to double raised a condition");
   a_logic_silent:
   assert property (ce && op_valid && cls inside {and_128, and_not_128, or_128, xor_128}
      |=> res_cond == 6'h00 && !simd_fp_trap) else $error("logic operation raised a condition");
   a_half_move_silent:
   assert property (ce && op_valid && cls inside {high_half_move, low_half_move, scalar_move}
      |=> res_cond == 6'h00 && !simd_fp_trap) else $error("half or scalar move raised a condition");
   a_shuffle_silent:
   assert property (ce && op_valid && cls inside {sign_mask_extract, shuffle_double, interleave_high_double,
      interleave_low_double}
      |=> res_cond == 6'h00 && !simd_fp_trap) else $error("shuffle or mask raised a condition");

   c_trap: cover property (ce && op_valid ##1 simd_fp_trap);
   c_default: cover property (ce && op_valid ##1 default_result);
   c_csr_read: cover property (avs_read && avs_address == csr_addr && !avs_waitrequest);
   c_packed_merge: cover property (ce && op_valid && op_packed && op_cond_hi != 6'h00 ##1 res_cond != 6'h00);

endmodule

// ---- rtl/simd_fp_exc_pkg.sv ----
/*
 Constants, class encodings and state layout for the double-precision
 exception map. Assumes a single core clock and a same-clock pipeline.
*/
package simd_fp_exc_pkg;

   // condition bit positions inside every six-bit condition vector
   localparam int cond_inv = 0;
   localparam int cond_den = 1;
   localparam int cond_divz = 2;
   localparam int cond_ovf = 3;
   localparam int cond_unf = 4;
   localparam int cond_prec = 5;
   localparam int cond_w = 6;

   // permitted-condition vectors per instruction family
   localparam logic [5:0] perm_all = 6'h3f;
   localparam logic [5:0] perm_arith = 6'h3b;
   localparam logic [5:0] perm_inv_den = 6'h03;
   localparam logic [5:0] perm_sqrt = 6'h23;
   localparam logic [5:0] perm_prec = 6'h20;
   localparam logic [5:0] perm_inv_prec = 6'h21;
   localparam logic [5:0] perm_none = 6'h00;

   // register map, byte addresses
   localparam int addr_w = 4;
   localparam logic [3:0] csr_addr = 4'h0;
   localparam logic [3:0] evt_addr = 4'h4;

   // control/status register field positions
   localparam int flag_lsb = 0;
   localparam int mask_lsb = 8;
   localparam int rmode_lsb = 16;
   // event register field positions
   localparam int last_raised_lsb = 0;
   localparam int last_class_lsb = 8;
   localparam int trap_cnt_lsb = 16;

   localparam logic [5:0] flags_reset = 6'h00;
   localparam logic [5:0] masks_reset = 6'h3f;
   localparam logic [1:0] rmode_reset = 2'h0;
   localparam logic [1:0] rmode_toward_zero = 2'h3;
   localparam logic [7:0] trap_vector_num = 8'h13;
   localparam logic [15:0] trap_cnt_one = 16'h0001;

   typedef enum logic [5:0] {
      add_packed_double = 6'b000000, add_scalar_double = 6'b000001,
      subtract_packed_double = 6'b000010, subtract_scalar_double = 6'b000011,
      multiply_packed_double = 6'b000100, multiply_scalar_double = 6'b000101,
      divide_packed_double = 6'b000110, divide_scalar_double = 6'b000111,
      compare_packed_double = 6'b001000, compare_scalar_double = 6'b001001,
      ordered_flag_compare = 6'b001010, unordered_flag_compare = 6'b001011,
      max_packed_double = 6'b001100, max_scalar_double = 6'b001101,
      min_packed_double = 6'b001110, min_scalar_double = 6'b001111,
      sqrt_packed_double = 6'b010000, sqrt_scalar_double = 6'b010001,
      int_to_single_packed = 6'b010010, single_to_int_round = 6'b010011,
      single_to_int_trunc = 6'b010100, double_to_int_round = 6'b010101,
      double_to_int_trunc = 6'b010110, double_to_mmx_int_round = 6'b010111,
      double_to_mmx_int_trunc = 6'b011000, scalar_double_to_gpr_round = 6'b011001,
      scalar_double_to_gpr_trunc = 6'b011010, double_to_single_packed = 6'b011011,
      scalar_double_to_single = 6'b011100, single_to_double_packed = 6'b011101,
      scalar_single_to_double = 6'b011110, int_to_double_packed = 6'b011111,
      mmx_int_to_double = 6'b100000, gpr_int_to_scalar_double = 6'b100001,
      and_128 = 6'b100010, and_not_128 = 6'b100011,
      or_128 = 6'b100100, xor_128 = 6'b100101,
      aligned_move_128 = 6'b100110, unaligned_move_128 = 6'b100111,
      high_half_move = 6'b101000, low_half_move = 6'b101001,
      scalar_move = 6'b101010, sign_mask_extract = 6'b101011,
      shuffle_double = 6'b101100, interleave_high_double = 6'b101101,
      interleave_low_double = 6'b101110
   } op_class_t;

   typedef enum logic {
      bus_idle = 1'b0,
      bus_ack = 1'b1
   } bus_state_t;

   typedef struct packed {
      bus_state_t bus;
      logic waitreq;
      logic [31:0] rdata;
      logic [5:0] flags;
      logic [5:0] masks;
      logic [1:0] rmode;
      logic [5:0] last_raised;
      logic [5:0] last_class;
      logic [15:0] trap_cnt;
      logic res_valid;
      logic [5:0] res_cond;
      logic dflt;
      logic trap;
      logic [7:0] vec;
      logic [1:0] rnd;
      logic gpr_wr;
   } state_t;

endpackage

// ---- tb/pipe_model.sv ----
/*
 Behavioural decode/execute front end that feeds one instruction per cycle
 into the exception map. Assumes the bench posts each request one cycle
 ahead on clk_sys; the model presents it on the following edge.
*/
`timescale 1ns/10ps
module pipe_model
   import simd_fp_exc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic go,
   input wire logic [5:0] req_class,
   input wire logic req_packed,
   input wire logic [5:0] req_lo,
   input wire logic [5:0] req_hi,
   output logic op_valid,
   output logic [5:0] op_class,
   output logic op_packed,
   output logic [5:0] op_cond_lo,
   output logic [5:0] op_cond_hi
);
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         op_valid <= 1'b0;
         op_class <= 6'h2a;
         op_packed <= 1'b1;
         op_cond_lo <= 6'h15;
         op_cond_hi <= 6'h2a;
      end
      else if (go)
      begin
         op_valid <= 1'b1;
         op_class <= req_class;
         op_packed <= req_packed;
         op_cond_lo <= req_lo;
         op_cond_hi <= req_hi;
      end
      else
      begin
         // idle lines churn so stale detections can never pass as real
         op_valid <= 1'b0;
         op_class <= ~op_class;
         op_packed <= ~op_packed;
         op_cond_lo <= ~op_cond_lo;
         op_cond_hi <= ~op_cond_hi;
      end
   end
endmodule

// ---- tb/simd_double_fp_exception_map_tb.sv ----
/*
 Self-checking bench for the double-precision exception map: Avalon access
 to the registers, every class code driven through the pipeline model.
 Assumes one 250 MHz clock and the design's one-cycle answers.
*/
`timescale 1ns/10ps
module simd_double_fp_exception_map_tb
   import simd_fp_exc_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0] avs_byteenable = 4'hf;
   logic go = 1'b0;
   logic [5:0] req_class = 6'h00;
   logic req_packed = 1'b0;
   logic [5:0] req_lo = 6'h00;
   logic [5:0] req_hi = 6'h00;
   wire logic [31:0] avs_readdata;
   wire logic avs_waitrequest;
   wire logic op_valid, op_packed, res_valid, default_result, simd_fp_trap, gpr_write;
   wire logic [5:0] op_class, op_cond_lo, op_cond_hi, res_cond;
   wire logic [7:0] trap_vector;
   wire logic [1:0] round_mode;
   int failures = 0;
   int check_count = 0;
   logic [31:0] q;

   always #2 clk_sys = ~clk_sys;

   pipe_model pipe_u (.clk_sys(clk_sys), .rstn(rstn), .go(go), .req_class(req_class),
      .req_packed(req_packed), .req_lo(req_lo), .req_hi(req_hi), .op_valid(op_valid),
      .op_class(op_class), .op_packed(op_packed), .op_cond_lo(op_cond_lo), .op_cond_hi(op_cond_hi));

   simd_double_fp_exception_map dut_u (.clk_sys(clk_sys), .rstn(rstn), .ce(ce),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .op_valid(op_valid), .op_class(op_class),
      .op_packed(op_packed), .op_cond_lo(op_cond_lo), .op_cond_hi(op_cond_hi),
      .res_valid(res_valid), .res_cond(res_cond), .default_result(default_result),
      .simd_fp_trap(simd_fp_trap), .trap_vector(trap_vector), .round_mode(round_mode),
      .gpr_write(gpr_write));

   function automatic logic [5:0] exp_perm(input logic [5:0] c);
      case (c)
         add_packed_double, add_scalar_double, subtract_packed_double, subtract_scalar_double,
         multiply_packed_double, multiply_scalar_double, double_to_single_packed,
         scalar_double_to_single: return perm_arith;
         divide_packed_double, divide_scalar_double: return perm_all;
         compare_packed_double, compare_scalar_double, ordered_flag_compare,
         unordered_flag_compare, max_packed_double, max_scalar_double, min_packed_double,
         min_scalar_double, single_to_double_packed, scalar_single_to_double: return perm_inv_den;
         sqrt_packed_double, sqrt_scalar_double: return perm_sqrt;
         int_to_single_packed: return perm_prec;
         single_to_int_round, single_to_int_trunc, double_to_int_round, double_to_int_trunc,
         double_to_mmx_int_round, double_to_mmx_int_trunc, scalar_double_to_gpr_round,
         scalar_double_to_gpr_trunc: return perm_inv_prec;
         default: return perm_none;
      endcase
   endfunction

   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // request held until waitrequest is sampled low; bounded wait
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (avs_waitrequest !== 1'b0)
      begin
         failures++;
         finish_test;
      end
   endtask

   task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk(what, exp, q);
   endtask

   task automatic op_chk(input logic [5:0] c, input logic [5:0] cond, input logic [5:0] m,
      input logic [1:0] rm);
      logic [5:0] r;
      logic t;
      r = exp_perm(c) & cond;
      t = (r & ~m) != 6'h00;
      chk("res_valid", 32'(1'b1), 32'(res_valid));
      chk("res_cond", 32'(r), 32'(res_cond));
      chk("default_result", 32'(r != 6'h00 && !t), 32'(default_result));
      chk("simd_fp_trap", 32'(t), 32'(simd_fp_trap));
      chk("trap_vector", 32'(t ? trap_vector_num : 8'h00), 32'(trap_vector));
      chk("round_mode", 32'(c inside {single_to_int_trunc, double_to_int_trunc, double_to_mmx_int_trunc,
         scalar_double_to_gpr_trunc} ? rmode_toward_zero : rm), 32'(round_mode));
      chk("gpr_write", 32'(c inside {scalar_double_to_gpr_round, scalar_double_to_gpr_trunc,
         sign_mask_extract}), 32'(gpr_write));
   endtask

   task automatic one_op(input logic [5:0] c, input logic p, input logic [5:0] lo,
      input logic [5:0] hi, input logic [5:0] m);
      @(posedge clk_sys);
      go <= 1'b1;
      req_class <= c;
      req_packed <= p;
      req_lo <= lo;
      req_hi <= hi;
      @(posedge clk_sys);
      go <= 1'b0;
      @(posedge clk_sys);
      #1 op_chk(c, lo | (p ? hi : 6'h00), m, 2'h0);
   endtask

   initial
   begin
      repeat (20) @(posedge clk_sys);
      rstn <= 1'b1;
      rd_chk("csr reset", csr_addr, 32'h0000_3f00);
      rd_chk("evt reset", evt_addr, 32'h0000_0000);
      rd_chk("unmapped", 4'h8, 32'h0000_0000);
      bus(1'b1, evt_addr, 32'hffff_ffff);
      rd_chk("evt read only", evt_addr, 32'h0000_0000);
      bus(1'b1, csr_addr, 32'h0002_3f00);
      rd_chk("csr write", csr_addr, 32'h0002_3f00);
      // every class back to back, lanes split so only their union is full
      for (int i = 0; i < 50; i++)
      begin
         @(posedge clk_sys);
         go <= (i < 48);
         req_class <= 6'(i);
         req_packed <= 1'b1;
         req_lo <= 6'h15;
         req_hi <= 6'h2a;
         #1 if (i >= 2) op_chk(6'(i - 2), 6'h3f, 6'h3f, 2'h2);
      end
      rd_chk("csr sticky", csr_addr, 32'h0002_3f3f);
      rd_chk("evt last", evt_addr, 32'h0000_1e03);
      bus(1'b1, csr_addr, 32'h0000_3b00);
      one_op(divide_scalar_double, 1'b0, 6'h04, 6'h3f, 6'h3b);
      one_op(add_packed_double, 1'b1, 6'h04, 6'h04, 6'h3b);
      one_op(divide_packed_double, 1'b1, 6'h00, 6'h01, 6'h3b);
      rd_chk("csr after trap", csr_addr, 32'h0000_3b05);
      rd_chk("evt after trap", evt_addr, 32'h0001_0601);
      // frozen core: an op offered while ce is low must leave no trace
      @(posedge clk_sys);
      ce <= 1'b0;
      go <= 1'b1;
      req_class <= divide_scalar_double;
      req_packed <= 1'b0;
      req_lo <= 6'h02;
      @(posedge clk_sys);
      go <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1 chk("frozen res_valid", 32'h0000_0000, 32'(res_valid));
      chk("frozen default_result", 32'h0000_0000, 32'(default_result));
      chk("frozen simd_fp_trap", 32'h0000_0000, 32'(simd_fp_trap));
      // the bus answer stretches until ce returns
      fork
         rd_chk("csr frozen", csr_addr, 32'h0000_3b05);
         begin
            repeat (4) @(posedge clk_sys);
            ce <= 1'b1;
         end
      join
      rd_chk("evt frozen", evt_addr, 32'h0001_0601);
      finish_test;
   end
endmodule
